/* src/pot_latch_pkg.sv */
// Package: constants and types for the wiper latch block
// =====================================================================
// =====================================================================
package pot_latch_pkg;

    localparam int        DATA_W        = 8;
    localparam int        TAP_COUNT     = 256;
    localparam int        SR_LEN_SINGLE = 8;
    localparam int        SR_LEN_DUAL   = 9;
    localparam int        CH_MAX        = 2;
    localparam int        SDO_TAP_POS   = 7;
    localparam int        ADDR_POS      = 8;
    localparam int        SYNC_STAGES   = 2;
    localparam logic [7:0] MIDSCALE_CODE = 8'h80;
    localparam logic [2:0] CTRL_RESET    = 3'h7;

    // Pin levels seen by the system clock domain
    typedef struct packed {
        logic chipSelectN;
        logic midscaleForceN;
        logic powerDownN;
    } ctrl_pins_type;

    // Switch controls toward the resistor network
    typedef struct packed {
        logic aTerminalOpen;
        logic wiperToB;
    } ladder_ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FRAME = 3'b010,
        ST_LOAD  = 3'b100
    } frame_state_type;

endpackage

/* src/level_sync.sv */
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [2:0] RESET_VAL = 3'h0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_r <= RESET_VAL[WIDTH-1:0];
            syncOut  <= RESET_VAL[WIDTH-1:0];
        end else begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end
endmodule
`default_nettype wire

/* src/tap_decoder.sv */
// Registered one-hot decode of a wiper code into tap switch enables
`timescale 1ns/1ps
`default_nettype none
module tap_decoder
    import pot_latch_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Code in, taps out
    input  wire logic [DATA_W-1:0]    code,
    output logic      [TAP_COUNT-1:0] tapOn
);
    wire [TAP_COUNT-1:0] tapNxt;
    wire [TAP_COUNT-1:0] tapMid;

    assign tapNxt = {{(TAP_COUNT-1){1'b0}}, 1'b1} << code;
    assign tapMid = {{(TAP_COUNT-1){1'b0}}, 1'b1} << MIDSCALE_CODE;

    always_ff @(posedge clk) begin
        if (reset) begin
            tapOn <= tapMid;
        end else begin
            tapOn <= tapNxt;
        end
    end
endmodule
`default_nettype wire

/* src/serial_pot_latch_ctrl.sv */
// Serial wiper latch controller: shift register, commit, preset, power-down
`timescale 1ns/1ps
`default_nettype none
module serial_pot_latch_ctrl
    import pot_latch_pkg::*;
#(
    parameter bit DUAL_CHANNEL = 1'b0
) (
    // System clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    // Serial link
    input  wire logic                              serialClk,
    input  wire logic                              chipSelectN,
    input  wire logic                              serialDataIn,
    output logic                                   serialDataOut,
    output logic                                   serialDataOutOe,
    // Control pins
    input  wire logic                              midscaleForceN,
    input  wire logic                              powerDownN,
    // Resistor network
    output logic      [CH_MAX-1:0][DATA_W-1:0]     wiperCode,
    output logic      [CH_MAX-1:0][TAP_COUNT-1:0]  tapSelect,
    output ladder_ctrl_type                        ladderCtrl,
    // Status
    output logic      [CH_MAX-1:0]                 latchUpdated,
    output logic                                   frameActive
);
    import pot_latch_pkg::*;

    // =================================================================
    // Build-time shape
    // =================================================================
    localparam int SR_LEN   = DUAL_CHANNEL ? SR_LEN_DUAL : SR_LEN_SINGLE;
    localparam int CH_COUNT = DUAL_CHANNEL ? CH_MAX : 1;

    // =================================================================
    // Link domain: serial shift register
    // =================================================================
    logic [SR_LEN-1:0] serialShiftRegister_r;
    logic              shiftOutBit_r;

    wire  [SR_LEN-1:0] shiftNxt;
    wire               frameLow;

    assign frameLow = ~chipSelectN;
    assign shiftNxt = {serialShiftRegister_r[SR_LEN-2:0], serialDataIn};

    // Shift only on rising serial clock inside a frame; between edges
    // the register simply holds
    always_ff @(posedge serialClk) begin
        if (frameLow) begin
            serialShiftRegister_r <= shiftNxt;
        end
    end

    // Serial output latch, cleared by preset whatever the clocks do
    always_ff @(posedge serialClk or negedge midscaleForceN) begin
        if (!midscaleForceN) begin
            shiftOutBit_r <= 1'b0;
        end else if (frameLow) begin
            shiftOutBit_r <= serialShiftRegister_r[SDO_TAP_POS];
        end
    end

    // =================================================================
    // System domain: pin synchronisers
    // =================================================================
    ctrl_pins_type pinsRaw;
    ctrl_pins_type pinsSync;

    assign pinsRaw.chipSelectN    = chipSelectN;
    assign pinsRaw.midscaleForceN = midscaleForceN;
    assign pinsRaw.powerDownN     = powerDownN;

    level_sync #(
        .WIDTH     (3),
        .RESET_VAL (CTRL_RESET)
    ) u_pin_sync (
        .clk     (clk),
        .reset   (reset),
        .asyncIn (pinsRaw),
        .syncOut (pinsSync)
    );

    wire presetActive;
    wire powerDownActive;
    wire frameSeen;

    assign presetActive    = ~pinsSync.midscaleForceN;
    assign powerDownActive = ~pinsSync.powerDownN;
    assign frameSeen       = ~pinsSync.chipSelectN;

    // =================================================================
    // System domain: frame tracking
    // =================================================================
    frame_state_type state_r;
    frame_state_type state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (frameSeen) begin
                    state_nxt = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (!frameSeen) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_nxt = frameSeen ? ST_FRAME : ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =================================================================
    // Commit decode
    // =================================================================
    // The shift register is static while chip select stays high, so the
    // word is read across domains only once the frame end is synchronised
    wire                commitWindow;
    wire                commitAllowed;
    wire [DATA_W-1:0]   wordData;
    wire                wordChannel;
    wire [CH_MAX-1:0]   channelHit;

    assign commitWindow  = (state_r == ST_LOAD);
    assign commitAllowed = commitWindow & ~presetActive
                         & ~powerDownActive;
    assign wordData      = serialShiftRegister_r[DATA_W-1:0];
    assign wordChannel   = DUAL_CHANNEL ?
                           serialShiftRegister_r[SR_LEN-1] : 1'b0;

    // One latch per word: bit zero picks the first, one the second
    assign channelHit[0] = commitAllowed & ~wordChannel;
    assign channelHit[1] = commitAllowed & wordChannel
                         & DUAL_CHANNEL;

    // =================================================================
    // Setting latches and tap decode
    // =================================================================
    logic [CH_MAX-1:0][DATA_W-1:0] resistorSettingLatch_r;
    logic [CH_MAX-1:0]             updated_r;

    genvar ch;
    generate
        for (ch = 0; ch < CH_MAX; ch++) begin : g_ch
            always_ff @(posedge clk) begin
                if (reset) begin
                    resistorSettingLatch_r[ch] <= MIDSCALE_CODE;
                    updated_r[ch]              <= 1'b0;
                end else if (presetActive) begin
                    // Held at mid-scale; release leaves it there
                    resistorSettingLatch_r[ch] <= MIDSCALE_CODE;
                    updated_r[ch]              <= 1'b0;
                end else if (channelHit[ch]) begin
                    resistorSettingLatch_r[ch] <= wordData;
                    updated_r[ch]              <= 1'b1;
                end else begin
                    updated_r[ch]              <= 1'b0;
                end
            end

            tap_decoder u_tap (
                .clk   (clk),
                .reset (reset),
                .code  (resistorSettingLatch_r[ch]),
                .tapOn (tapSelect[ch])
            );
        end
    endgenerate

    assign wiperCode    = resistorSettingLatch_r;
    assign latchUpdated = updated_r;

    // =================================================================
    // Power-down and ladder switches
    // =================================================================
    ladder_ctrl_type ladder_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            ladder_r <= '0;
        end else begin
            ladder_r.aTerminalOpen <= powerDownActive;
            ladder_r.wiperToB      <= powerDownActive;
        end
    end

    assign ladderCtrl = ladder_r;

    // =================================================================
    // Open-drain serial output
    // =================================================================
    logic frameActive_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            frameActive_r <= 1'b0;
        end else begin
            frameActive_r <= frameSeen;
        end
    end

    wire driveWindow;

    assign driveWindow     = frameSeen & ~powerDownActive;
    assign serialDataOut   = 1'b0;
    assign serialDataOutOe = driveWindow & ~shiftOutBit_r;
    assign frameActive     = frameActive_r;

    // Channel count is not used by the decode above; DUAL_CHANNEL shapes it
    wire unusedShape;
    assign unusedShape = (CH_COUNT == 0);

endmodule
`default_nettype wire

/* dv/serial_pot_latch_ctrl_assertions.sv */
// Concurrent checks on the ports of the wiper latch controller
`timescale 1ns/1ps
`default_nettype none
module serial_pot_latch_ctrl_assertions
    import pot_latch_pkg::*;
(
    // Clock and reset
    input wire logic                             clk,
    input wire logic                             reset,
    // Pins
    input wire logic                             chipSelectN,
    input wire logic                             midscaleForceN,
    input wire logic                             powerDownN,
    input wire logic                             serialDataOut,
    input wire logic                             serialDataOutOe,
    // Network side
    input wire logic [CH_MAX-1:0][DATA_W-1:0]    wiperCode,
    input wire logic [CH_MAX-1:0][TAP_COUNT-1:0] tapSelect,
    input wire ladder_ctrl_type                  ladderCtrl,
    input wire logic [CH_MAX-1:0]                latchUpdated,
    input wire logic                             frameActive
);
    localparam logic [TAP_COUNT-1:0] TAP_ONE = 256'h1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // =====================================================
    // Assertions
    AST_OD_LOW: assert property (serialDataOut == 1'b0)
        else $error("open-drain data not low");
    AST_PD_OE: assert property (!powerDownN [*4] |=> !serialDataOutOe)
        else $error("output driven in power-down");
    AST_PD_LADDER: assert property (!powerDownN [*4] |=>
        {ladderCtrl.aTerminalOpen, ladderCtrl.wiperToB} == 2'h3)
        else $error("ladder not switched in power-down");
    AST_PD_HOLD: assert property ((!powerDownN && midscaleForceN) [*4]
        |=> $stable(wiperCode)) else $error("code moved in power-down");
    AST_PRESET: assert property (!midscaleForceN [*4] |=>
        wiperCode == {CH_MAX{MIDSCALE_CODE}}) else $error("preset ignored");
    AST_ONE_LOAD: assert property ($onehot0(latchUpdated))
        else $error("two latches loaded");
    AST_LOAD_PULSE: assert property (|latchUpdated |=> latchUpdated == 2'h0)
        else $error("load pulse too long");
    AST_LOAD_COND: assert property (|latchUpdated |-> $past(chipSelectN, 3)
        && $past(powerDownN, 3) && $past(midscaleForceN, 3))
        else $error("load without chip select rise");
    AST_WIPER_CAUSE: assert property (!$stable(wiperCode) |-> |latchUpdated
        || wiperCode == {CH_MAX{MIDSCALE_CODE}}) else $error("stray code");
    AST_TAP: assert property (1'b1 |=> tapSelect ==
        {TAP_ONE << $past(wiperCode[1]), TAP_ONE << $past(wiperCode[0])})
        else $error("tap decode wrong");
    AST_OE_IDLE: assert property (chipSelectN [*4] |=> !serialDataOutOe)
        else $error("output driven outside frame");
    AST_FRAME_ON: assert property (!chipSelectN [*3] |=> frameActive)
        else $error("frame not flagged");
    AST_FRAME_OFF: assert property (chipSelectN [*3] |=> !frameActive)
        else $error("frame flag stuck");
    // =====================================================
    // Covers
    COV_LOAD0: cover property (latchUpdated[0]);
    COV_LOAD1: cover property (latchUpdated[1]);
    COV_PD_FRAME: cover property (ladderCtrl.aTerminalOpen && !chipSelectN);
endmodule
`default_nettype wire

/* dv/pot_host_model.sv */
// Host model driving the serial link of the wiper latch block
`timescale 1ns/1ps
`default_nettype none
module pot_host_model (
    // System clock
    input  wire logic clk,
    // Serial link
    output logic      serialClk,
    output logic      chipSelectN,
    output logic      serialDataIn,
    input  wire logic sdoLine
);
    initial begin
        serialClk    = 1'b0;
        chipSelectN  = 1'b1;
        serialDataIn = 1'b0;
    end
    // One framed word, MSB first; link clock runs only in the frame
    task automatic send(input logic [15:0] w, input int n,
                        output logic [15:0] got);
        got = 16'h0000;
        @(posedge clk) chipSelectN <= 1'b0;
        repeat (4) @(posedge clk);
        #7;
        for (int i = 0; i < n; i++) begin
            serialDataIn <= w[n-1-i];
            #24 serialClk <= 1'b1;
            #23 got = {got[14:0], sdoLine};
            #1 serialClk <= 1'b0;
        end
        #24 serialDataIn <= ~serialDataIn;
        @(posedge clk) chipSelectN <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* dv/serial_pot_latch_ctrl_test.sv */
// Self-checking bench for the serial wiper latch controller
`timescale 1ns/1ps
`default_nettype none
module serial_pot_latch_ctrl_test;
    import pot_latch_pkg::*;
    logic                             clk, reset, serialClk, chipSelectN;
    logic                             serialDataIn, serialDataOut;
    logic                             serialDataOutOe, frameActive;
    logic                             midscaleForceN, powerDownN;
    logic [CH_MAX-1:0][DATA_W-1:0]    wiperCode;
    logic [CH_MAX-1:0][TAP_COUNT-1:0] tapSelect;
    ladder_ctrl_type                  ladderCtrl;
    logic [CH_MAX-1:0]                latchUpdated;
    logic [DATA_W-1:0]                expCode [CH_MAX];
    logic [15:0]                      word, got;
    int                               nBits;
    int                               err_total = 0;
    int                               checks = 0;
    int                               loads = 0;
    wire                              sdoLine;
    // Open-drain line with pull-up
    assign sdoLine = serialDataOutOe ? serialDataOut : 1'b1;
    serial_pot_latch_ctrl #(.DUAL_CHANNEL(1'b1)) dut (
        .clk(clk), .reset(reset), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe),
        .midscaleForceN(midscaleForceN), .powerDownN(powerDownN),
        .wiperCode(wiperCode), .tapSelect(tapSelect),
        .ladderCtrl(ladderCtrl), .latchUpdated(latchUpdated),
        .frameActive(frameActive));
    pot_host_model host (.clk(clk), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialDataIn(serialDataIn),
        .sdoLine(sdoLine));
    // Count latch load pulses
    always @(posedge clk) begin
        if (!reset) begin
            loads <= loads + int'(latchUpdated[0]) + int'(latchUpdated[1]);
        end
    end
    // =====================================================
    // Helpers
    function automatic logic [TAP_COUNT-1:0] tap_of(input logic [7:0] c);
        return {{(TAP_COUNT-1){1'b0}}, 1'b1} << c;
    endfunction
    task automatic check(input logic [TAP_COUNT-1:0] seen, exp,
                         input string msg);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic frame(input logic [15:0] w, input int n);
        logic [15:0] mask;
        mask = (16'h0001 << (n - 8)) - 16'h0001;
        host.send(w, n, got);
        if (powerDownN)
            check(got & mask, (w >> 8) & mask, "daisy output");
        else
            check(got[8:0], 9'h1ff, "output released");
    endtask
    task automatic expect_codes(input string msg);
        #1;
        check(wiperCode[0], expCode[0], msg);
        check(wiperCode[1], expCode[1], msg);
        check(tapSelect[0], tap_of(expCode[0]), "tap 0");
        check(tapSelect[1], tap_of(expCode[1]), "tap 1");
    endtask
    // =====================================================
    // Clock and sequence
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #1_000_000;
        err_total++;
        $display("CHECK FAILED at %0t: run hung", $time);
        tally_and_finish();
    end
    initial begin
        reset = 1'b1;
        midscaleForceN = 1'b1;
        powerDownN = 1'b1;
        expCode[0] = MIDSCALE_CODE;
        expCode[1] = MIDSCALE_CODE;
        void'($urandom(81983));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        expect_codes("power-on code");
        check(ladderCtrl, 2'h0, "ladder idle");
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            word = 16'($urandom);
            if (i < 4) word[8] = i[0];
            if (i < 2) word[7:0] = i[0] ? 8'hff : 8'h00;
            nBits = (i > 8) ? 16 : 9;
            expCode[word[8]] = word[7:0];
            frame(word, nBits);
            expect_codes("serial load");
        end
        check(loads, 12, "load pulse count");
        $display("test loads done");
        @(posedge clk) powerDownN <= 1'b0;
        repeat (5) @(posedge clk);
        #1 check(ladderCtrl, 2'h3, "ladder off");
        frame({7'h00, 1'b0, ~expCode[0]}, 9);
        expect_codes("power-down hold");
        @(posedge clk) powerDownN <= 1'b1;
        repeat (5) @(posedge clk);
        expect_codes("resume");
        check(ladderCtrl, 2'h0, "ladder back");
        $display("test power-down done");
        @(posedge clk) midscaleForceN <= 1'b0;
        repeat (5) @(posedge clk);
        expCode[0] = MIDSCALE_CODE;
        expCode[1] = MIDSCALE_CODE;
        expect_codes("preset");
        @(posedge clk) midscaleForceN <= 1'b1;
        repeat (5) @(posedge clk);
        expect_codes("preset released");
        check(loads, 12, "no load in power-down or preset");
        $display("test preset done");
        tally_and_finish();
    end
endmodule
bind serial_pot_latch_ctrl serial_pot_latch_ctrl_assertions chk (
    .clk(clk), .reset(reset), .chipSelectN(chipSelectN),
    .midscaleForceN(midscaleForceN), .powerDownN(powerDownN),
    .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe),
    .wiperCode(wiperCode), .tapSelect(tapSelect),
    .ladderCtrl(ladderCtrl), .latchUpdated(latchUpdated),
    .frameActive(frameActive));
`default_nettype wire
